// ===== verilog/lpc_cycle_pkg.sv
// Shared constants and types for the single-byte memory cycle link
package lpc_cycle_pkg;

   // Nibble codes seen on the four bus lines
   localparam int NIB_W = 4;
   localparam logic [3:0] NIB_START_MEM = 4'h0;
   localparam logic [3:0] NIB_TURN = 4'hf;
   localparam logic [3:0] NIB_SYNC_READY = 4'h0;
   localparam logic [3:0] NIB_ABORT = 4'hf;
   localparam logic [3:0] NIB_IDLE = 4'hf;

   // Cycle type and direction nibble
   localparam logic [1:0] TYPE_MEM = 2'h1;
   localparam int TYPE_DIR_BIT = 1;

   // Clock numbers within one cycle
   localparam logic [4:0] CLK_START = 5'h01;
   localparam logic [4:0] CLK_TYPE = 5'h02;
   localparam logic [4:0] CLK_ADDR_FIRST = 5'h03;
   localparam logic [4:0] CLK_ADDR_LAST = 5'h0a;
   localparam logic [4:0] CLK_RD_HOST_TAR = 5'h0b;
   localparam logic [4:0] CLK_RD_TAKE = 5'h0c;
   localparam logic [4:0] CLK_RD_SYNC = 5'h0d;
   localparam logic [4:0] CLK_RD_DLO = 5'h0e;
   localparam logic [4:0] CLK_RD_DHI = 5'h0f;
   localparam logic [4:0] CLK_WR_DLO = 5'h0b;
   localparam logic [4:0] CLK_WR_DHI = 5'h0c;
   localparam logic [4:0] CLK_WR_HOST_TAR = 5'h0d;
   localparam logic [4:0] CLK_WR_TAKE = 5'h0e;
   localparam logic [4:0] CLK_WR_SYNC = 5'h0f;
   localparam logic [4:0] CLK_DEV_TAR = 5'h10;
   localparam logic [4:0] CLK_END = 5'h11;

   // Address field layout
   localparam int ADDR_W = 32;
   localparam logic [7:0] ADDR_TOP_VALUE = 8'hff;
   localparam int ADDR_TOP_LSB = 24;
   localparam int ADDR_ID_HI_BIT = 23;
   localparam int ADDR_MEM_BIT = 22;
   localparam int ADDR_ID_LO_MSB = 21;
   localparam int ADDR_ID_LO_LSB = 19;
   localparam int ADDR_OFFSET_W = 19;
   localparam int STRAP_W = 4;
   localparam int DATA_W = 8;

   // Device end states
   typedef enum logic [3:0] {
      DEV_IDLE = 4'h1,
      DEV_START = 4'h2,
      DEV_ADDR = 4'h4,
      DEV_BODY = 4'h8
   } dev_state_type;

   // Host end states
   typedef enum logic [2:0] {
      HOST_IDLE = 3'h1,
      HOST_CYCLE = 3'h2,
      HOST_ABORT = 3'h4
   } host_state_type;

endpackage

// ===== verilog/lpc_link_if.sv
// Link between host end and device end, with bus line resolution
`timescale 1ns/100ps
interface lpc_link_if;
   import lpc_cycle_pkg::*;

   logic frameN;
   logic [3:0] hostLad;
   logic hostLadOeN;
   logic [3:0] devLad;
   logic devLadOeN;
   logic [3:0] lad;

   // Host wins a clash; undriven lines float high by pull-up
   assign lad = !hostLadOeN ? hostLad : (!devLadOeN ? devLad : NIB_IDLE);

   modport host (
      output frameN,
      output hostLad,
      output hostLadOeN,
      input lad
   );

   modport device (
      input frameN,
      input lad,
      output devLad,
      output devLadOeN
   );
endinterface

// ===== verilog/strap_sync.sv
// Two-stage synchroniser for static strap pins
`timescale 1ns/100ps
module strap_sync #(
   parameter int WIDTH = 4,
   parameter int STAGES = 2
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);
   logic [STAGES-1:0][WIDTH-1:0] stage_q;

   // Refuse settings the chain cannot serve
   if (STAGES < 2 || WIDTH < 1) begin : g_check
      $error("strap_sync needs at least two stages and one bit");
   end

   // Shift chain; only the last stage is read
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         stage_q <= '0;
      end
      else
      begin
         stage_q <= {stage_q[STAGES-2:0], pinIn};
      end
   end

   assign pinOut = stage_q[STAGES-1];
endmodule // strap_sync

// ===== verilog/lpc_target_end.sv
// Device end: decodes memory cycles and answers with sync, and with data on reads
`timescale 1ns/100ps
module lpc_target_end (
   input wire logic sys_clk,
   input wire logic reset_n,
   lpc_link_if.device link,
   input wire logic [lpc_cycle_pkg::STRAP_W-1:0] strapSelectPins,
   input wire logic busy,
   input wire logic [lpc_cycle_pkg::DATA_W-1:0] readData,
   output logic readStrobe,
   output logic writeStrobe,
   output logic accessMem,
   output logic [lpc_cycle_pkg::ADDR_OFFSET_W-1:0] accessAddr,
   output logic [lpc_cycle_pkg::DATA_W-1:0] writeData
);
   import lpc_cycle_pkg::*;

   typedef struct packed {
      dev_state_type state;
      logic [4:0] clkNum;
      logic startOk;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [3:0] ladOut;
      logic ladOeN;
      logic rdStrobe;
      logic wrStrobe;
   } dev_regs_type;

   localparam dev_regs_type REGS_RESET = '{
      state: DEV_IDLE,
      clkNum: '0,
      startOk: 1'b0,
      write: 1'b0,
      addr: '0,
      data: '0,
      ladOut: NIB_IDLE,
      ladOeN: 1'b1,
      rdStrobe: 1'b0,
      wrStrobe: 1'b0
   };

   dev_regs_type s_q;
   dev_regs_type s_d;
   logic [STRAP_W-1:0] strapSync;
   logic [ADDR_W-1:0] addrNext;
   logic [4:0] clkNext;
   logic [4:0] drive;

   // Strap pins come from outside and pass two flip-flops
   strap_sync #(
      .WIDTH(STRAP_W),
      .STAGES(2)
   ) u_strap_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pinIn(strapSelectPins),
      .pinOut(strapSync)
   );

   // Top byte and select bits of a finished address
   function automatic logic idHit(input logic [ADDR_W-1:0] a,
                                  input logic [STRAP_W-1:0] strap);
      logic [STRAP_W-1:0] sel;
      sel = {a[ADDR_ID_HI_BIT], a[ADDR_ID_LO_MSB:ADDR_ID_LO_LSB]};
      idHit = (a[ADDR_W-1:ADDR_TOP_LSB] == ADDR_TOP_VALUE) &&
              (sel == ~strap);
   endfunction

   // Drive plan for the coming clock: {output enable low, nibble}
   function automatic logic [4:0] busNibble(input logic wr,
                                            input logic [4:0] c,
                                            input logic [DATA_W-1:0] d);
      busNibble = {1'b1, NIB_IDLE};
      if (!wr)
      begin
         case (c)
            CLK_RD_TAKE: busNibble = {1'b0, NIB_TURN};
            CLK_RD_SYNC: busNibble = {1'b0, NIB_SYNC_READY};
            CLK_RD_DLO: busNibble = {1'b0, d[3:0]};
            CLK_RD_DHI: busNibble = {1'b0, d[7:4]};
            CLK_DEV_TAR: busNibble = {1'b0, NIB_TURN};
            default: busNibble = {1'b1, NIB_IDLE};
         endcase
      end
      else
      begin
         case (c)
            CLK_WR_TAKE: busNibble = {1'b0, NIB_TURN};
            CLK_WR_SYNC: busNibble = {1'b0, NIB_SYNC_READY};
            CLK_DEV_TAR: busNibble = {1'b0, NIB_TURN};
            default: busNibble = {1'b1, NIB_IDLE};
         endcase
      end
   endfunction

   // Address as it stands after this edge's nibble
   assign addrNext = {s_q.addr[ADDR_W-NIB_W-1:0], link.lad};
   assign clkNext = s_q.clkNum + 5'h01;

   // Next-state logic; the bus is read only at the rising edge
   always_comb
   begin
      s_d = s_q;
      s_d.rdStrobe = 1'b0;
      s_d.wrStrobe = 1'b0;
      s_d.ladOut = NIB_IDLE;
      s_d.ladOeN = 1'b1;
      drive = {1'b1, NIB_IDLE};
      if (!link.frameN)
      begin
         // Frame low always restarts; later nibble overrides earlier
         s_d.state = DEV_START;
         s_d.clkNum = CLK_START;
         s_d.startOk = (link.lad == NIB_START_MEM);
      end
      else
      begin
         case (s_q.state)
            DEV_IDLE:
            begin
               s_d.state = DEV_IDLE;
            end
            DEV_START:
            begin
               // Bit 0 of the type nibble is not looked at
               if (s_q.startOk && link.lad[3:2] == TYPE_MEM)
               begin
                  s_d.state = DEV_ADDR;
                  s_d.clkNum = CLK_TYPE;
                  s_d.write = link.lad[TYPE_DIR_BIT];
                  s_d.addr = '0;
               end
               else
               begin
                  s_d.state = DEV_IDLE;
               end
            end
            DEV_ADDR:
            begin
               s_d.clkNum = clkNext;
               s_d.addr = addrNext;
               if (clkNext == CLK_ADDR_LAST)
               begin
                  if (idHit(addrNext, strapSync))
                  begin
                     s_d.state = DEV_BODY;
                     s_d.rdStrobe = !s_q.write;
                  end
                  else
                  begin
                     s_d.state = DEV_IDLE;
                  end
               end
            end
            DEV_BODY:
            begin
               s_d.clkNum = clkNext;
               if (s_q.write && clkNext == CLK_WR_DLO)
               begin
                  s_d.data[3:0] = link.lad;
               end
               if (s_q.write && clkNext == CLK_WR_DHI)
               begin
                  s_d.data[7:4] = link.lad;
                  s_d.wrStrobe = !busy;
               end
               if (!s_q.write && clkNext == CLK_RD_HOST_TAR + 5'h01)
               begin
                  s_d.data = readData;
               end
               drive = busNibble(s_q.write, clkNext + 5'h01, s_d.data);
               s_d.ladOeN = drive[4];
               s_d.ladOut = drive[3:0];
               if (clkNext == CLK_DEV_TAR)
               begin
                  s_d.state = DEV_IDLE;
               end
            end
            default:
            begin
               s_d.state = DEV_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         s_q <= REGS_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign link.devLad = s_q.ladOut;
   assign link.devLadOeN = s_q.ladOeN;
   assign readStrobe = s_q.rdStrobe;
   assign writeStrobe = s_q.wrStrobe;
   assign accessMem = s_q.addr[ADDR_MEM_BIT];
   assign accessAddr = s_q.addr[ADDR_OFFSET_W-1:0];
   assign writeData = s_q.data;
endmodule // lpc_target_end

// ===== verilog/lpc_host_end.sv
// Host end: issues single-byte memory reads and writes
`timescale 1ns/100ps
module lpc_host_end (
   input wire logic sys_clk,
   input wire logic reset_n,
   lpc_link_if.host link,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [lpc_cycle_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [lpc_cycle_pkg::DATA_W-1:0] reqData,
   input wire logic abortReq,
   output logic reqReady,
   output logic doneStrobe,
   output logic doneError,
   output logic [lpc_cycle_pkg::DATA_W-1:0] doneData
);
   import lpc_cycle_pkg::*;

   typedef struct packed {
      host_state_type state;
      logic [4:0] clkNum;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic frameN;
      logic [3:0] ladOut;
      logic ladOeN;
      logic done;
      logic error;
   } host_regs_type;

   localparam host_regs_type REGS_RESET = '{
      state: HOST_IDLE,
      clkNum: '0,
      write: 1'b0,
      addr: '0,
      data: '0,
      frameN: 1'b1,
      ladOut: NIB_IDLE,
      ladOeN: 1'b0,
      done: 1'b0,
      error: 1'b0
   };

   host_regs_type s_q;
   host_regs_type s_d;
   logic [4:0] clkNext;
   logic [4:0] drive;
   logic syncBad;

   // Drive plan for clock c: {output enable low, nibble}
   function automatic logic [4:0] hostNibble(input logic wr,
                                             input logic [4:0] c,
                                             input logic [ADDR_W-1:0] a,
                                             input logic [DATA_W-1:0] d);
      logic [ADDR_W-1:0] sh;
      logic [6:0] amount;
      amount = {c - CLK_ADDR_FIRST, 2'b00};
      sh = a << amount;
      hostNibble = {1'b1, NIB_IDLE};
      if (c == CLK_TYPE)
      begin
         hostNibble = {1'b0, TYPE_MEM, wr, 1'b0};
      end
      else if (c >= CLK_ADDR_FIRST && c <= CLK_ADDR_LAST)
      begin
         hostNibble = {1'b0, sh[ADDR_W-1:ADDR_W-NIB_W]};
      end
      else if (!wr && c == CLK_RD_HOST_TAR)
      begin
         hostNibble = {1'b0, NIB_TURN};
      end
      else if (wr && c == CLK_WR_DLO)
      begin
         hostNibble = {1'b0, d[3:0]};
      end
      else if (wr && c == CLK_WR_DHI)
      begin
         hostNibble = {1'b0, d[7:4]};
      end
      else if (wr && c == CLK_WR_HOST_TAR)
      begin
         hostNibble = {1'b0, NIB_TURN};
      end
      else if (c == CLK_END)
      begin
         hostNibble = {1'b0, NIB_IDLE};
      end
   endfunction

   // Next clock number and the sync check
   assign clkNext = s_q.clkNum + 5'h01;
   assign syncBad = link.lad != NIB_SYNC_READY &&
                    s_q.clkNum == (s_q.write ? CLK_WR_SYNC : CLK_RD_SYNC);

   // Next-state logic; bus sampled at the rising edge
   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.error = 1'b0;
      s_d.frameN = 1'b1;
      s_d.ladOut = NIB_IDLE;
      s_d.ladOeN = 1'b0;
      drive = {1'b1, NIB_IDLE};
      case (s_q.state)
         HOST_IDLE:
         begin
            if (reqValid)
            begin
               s_d.state = HOST_CYCLE;
               s_d.clkNum = CLK_START;
               s_d.write = reqWrite;
               s_d.addr = reqAddr;
               s_d.data = reqData;
               s_d.frameN = 1'b0;
               s_d.ladOut = NIB_START_MEM;
            end
         end
         HOST_CYCLE:
         begin
            if (abortReq || syncBad)
            begin
               // One clock of frame low with the abort nibble
               s_d.state = HOST_ABORT;
               s_d.frameN = 1'b0;
               s_d.ladOut = NIB_ABORT;
               s_d.done = 1'b1;
               s_d.error = 1'b1;
            end
            else if (s_q.clkNum == CLK_END)
            begin
               s_d.state = HOST_IDLE;
               s_d.done = 1'b1;
            end
            else
            begin
               if (!s_q.write && s_q.clkNum == CLK_RD_DLO)
               begin
                  s_d.data[3:0] = link.lad;
               end
               if (!s_q.write && s_q.clkNum == CLK_RD_DHI)
               begin
                  s_d.data[7:4] = link.lad;
               end
               s_d.clkNum = clkNext;
               drive = hostNibble(s_q.write, clkNext, s_q.addr, s_q.data);
               s_d.ladOeN = drive[4];
               s_d.ladOut = drive[3:0];
            end
         end
         HOST_ABORT:
         begin
            s_d.state = HOST_IDLE;
         end
         default:
         begin
            s_d.state = HOST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         s_q <= REGS_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign link.frameN = s_q.frameN;
   assign link.hostLad = s_q.ladOut;
   assign link.hostLadOeN = s_q.ladOeN;
   assign reqReady = (s_q.state == HOST_IDLE);
   assign doneStrobe = s_q.done;
   assign doneError = s_q.error;
   assign doneData = s_q.data;
endmodule // lpc_host_end

// ===== test/lpc_memory_cycle_target_props.sv
// Concurrent checks on the link between host end and device end
`timescale 1ns/100ps
module lpc_memory_cycle_target_props (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic frameN,
   input wire logic [3:0] hostLad,
   input wire logic hostLadOeN,
   input wire logic [3:0] devLad,
   input wire logic devLadOeN,
   input wire logic [3:0] lad
);
   import lpc_cycle_pkg::*;

   logic [4:0] clkNum_q;
   logic start_q;
   logic write_q;

   // Clock number in the cycle, start code and direction seen
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         clkNum_q <= 5'h00;
         start_q <= 1'b0;
         write_q <= 1'b0;
      end
      else if (!frameN)
      begin
         clkNum_q <= CLK_TYPE;
         start_q <= (lad == NIB_START_MEM);
      end
      else
      begin
         if (clkNum_q != 5'h00 && clkNum_q != 5'h1f)
            clkNum_q <= clkNum_q + 5'h01;
         if (clkNum_q == CLK_TYPE)
            write_q <= lad[TYPE_DIR_BIT];
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   drive_window_a:
      assert property (!devLadOeN |-> start_q && clkNum_q >= CLK_RD_TAKE
         && clkNum_q <= CLK_DEV_TAR)
      else $error("device drives outside its clocks");
   frame_drop_a:
      assert property (!frameN |=> devLadOeN)
      else $error("device kept bus after frame low");
   take_clock_a:
      assert property ($fell(devLadOeN) |->
         clkNum_q == (write_q ? CLK_WR_TAKE : CLK_RD_TAKE))
      else $error("device took bus in wrong clock");
   sync_follow_a:
      assert property ($fell(devLadOeN) |-> devLad == NIB_TURN
         ##1 (!devLadOeN && devLad == NIB_SYNC_READY))
      else $error("sync nibble missing after take");
   turn_end_a:
      assert property (!devLadOeN && clkNum_q == CLK_DEV_TAR |->
         devLad == NIB_TURN ##1 devLadOeN)
      else $error("device closing turnaround wrong");
   host_back_a:
      assert property (clkNum_q == CLK_END |-> !hostLadOeN && devLadOeN)
      else $error("host not owning bus at last clock");
   host_turn_a:
      assert property (start_q && clkNum_q == (write_q ? CLK_WR_HOST_TAR
         : CLK_RD_HOST_TAR) |-> !hostLadOeN && hostLad == NIB_TURN
         ##1 hostLadOeN)
      else $error("host turnaround wrong");
   type_field_a:
      assert property (start_q && frameN && clkNum_q == CLK_TYPE |->
         lad[3:2] == TYPE_MEM)
      else $error("host sent non-memory type");

   // Main scenarios reached
   read_cov: cover property ($fell(devLadOeN) && !write_q);
   write_cov: cover property ($fell(devLadOeN) && write_q);
   abort_cov: cover property (start_q && !frameN && clkNum_q > CLK_TYPE);
endmodule // lpc_memory_cycle_target_props

// ===== test/lpc_memory_cycle_target_tb.sv
// Bench joining host end and device end, plus a raw-driven device end
`timescale 1ns/100ps
module lpc_memory_cycle_target_tb;
   import lpc_cycle_pkg::*;

   localparam logic [31:0] RAW_ADDR = 32'hfff9_2345;
   logic sys_clk, reset_n, busy, reqValid, reqWrite, abortReq;
   logic readStrobe, writeStrobe, accessMem, readStrobeB;
   logic reqReady, doneStrobe, doneError;
   logic [3:0] strap;
   logic [7:0] readData, reqData, doneData, writeData;
   logic [31:0] reqAddr;
   logic [18:0] accessAddr, accessAddrB;
   logic [3:0] nib [0:18];
   logic dn, de;
   int rsCnt, wsCnt, nFail, totalChecks;

   lpc_link_if link ();
   lpc_link_if linkB ();

   lpc_host_end u_lpc_host_end (.sys_clk(sys_clk), .reset_n(reset_n),
      .link(link), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqData(reqData), .abortReq(abortReq),
      .reqReady(reqReady), .doneStrobe(doneStrobe),
      .doneError(doneError), .doneData(doneData));
   lpc_target_end u_lpc_target_end (.sys_clk(sys_clk), .reset_n(reset_n),
      .link(link), .strapSelectPins(strap), .busy(busy),
      .readData(readData), .readStrobe(readStrobe),
      .writeStrobe(writeStrobe), .accessMem(accessMem),
      .accessAddr(accessAddr), .writeData(writeData));
   // Second device end, its host side driven by hand
   lpc_target_end u_lpc_target_end_b (.sys_clk(sys_clk),
      .reset_n(reset_n), .link(linkB), .strapSelectPins(4'h0),
      .busy(busy), .readData(readData), .readStrobe(readStrobeB),
      .writeStrobe(), .accessMem(), .accessAddr(accessAddrB),
      .writeData());
   lpc_memory_cycle_target_props u_lpc_memory_cycle_target_props (
      .sys_clk(sys_clk), .reset_n(reset_n), .frameN(link.frameN),
      .hostLad(link.hostLad), .hostLadOeN(link.hostLadOeN),
      .devLad(link.devLad), .devLadOeN(link.devLadOeN), .lad(link.lad));

   // 50 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Compare one value and count a mismatch
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         nFail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Print the counts and the verdict, then stop
   task automatic endSim();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One host request; records bus nibbles and strobes per clock
   task automatic run(input logic wr, input logic [31:0] a,
      input logic [7:0] d, input int abortAt);
      int n;
      n = 0;
      {rsCnt, wsCnt, dn, de} = '0;
      reqValid <= 1'b1;
      reqWrite <= wr;
      reqAddr <= a;
      reqData <= d;
      @(posedge sys_clk);
      while (!reqReady && n < 40)
      begin
         n++;
         @(posedge sys_clk);
      end
      reqValid <= 1'b0;
      chk("request taken", reqReady, 1'b1);
      for (int k = 1; k <= 18; k++)
      begin
         @(posedge sys_clk);
         abortReq <= (k == abortAt);
         nib[k] = link.lad;
         rsCnt += readStrobe;
         wsCnt += writeStrobe;
         dn |= doneStrobe;
         de |= doneError;
      end
   endtask

   task automatic t_read(input logic [7:0] d);
      readData <= d;
      run(1'b0, 32'hfffa_bcde, 8'h00, 0);
      chk("read strobe", rsCnt, 1);
      chk("read addr", accessAddr, 19'h2bcde);
      chk("read space", accessMem, 1'b1);
      chk("read sync", nib[13], NIB_SYNC_READY);
      chk("read data order", {nib[15], nib[14]}, d);
      chk("dev turn", nib[16], NIB_TURN);
      chk("read done", {dn, de, doneData}, {2'b10, d});
      $display("test read done");
   endtask

   task automatic t_write(input logic b);
      busy <= b;
      run(1'b1, 32'hffbd_0042, 8'hc3, 0);
      chk("write data order", {nib[12], nib[11]}, 8'hc3);
      chk("host turn", nib[13], NIB_TURN);
      chk("write sync", nib[15], NIB_SYNC_READY);
      chk("write strobe", wsCnt, !b);
      chk("write done", {dn, de}, 2'b10);
      if (!b)
         chk("write fields", {accessMem, accessAddr, writeData},
            {1'b0, 19'h50042, 8'hc3});
      if (b)
         busy <= 1'b0;
      $display("test write done");
   endtask

   task automatic t_abort();
      run(1'b0, 32'hfffa_bcde, 8'h00, 5);
      chk("abort strobe", rsCnt, 0);
      chk("abort done", {dn, de}, 2'b11);
      $display("test abort done");
      t_read(8'h3c);
   endtask

   task automatic t_strap();
      strap <= 4'h3;
      repeat (4) @(posedge sys_clk);
      run(1'b0, 32'hfffa_bcde, 8'h00, 0);
      chk("foreign strobe", rsCnt, 0);
      chk("foreign silent", {nib[13], de}, {NIB_IDLE, 1'b1});
      readData <= 8'h96;
      run(1'b0, 32'hffe0_0010, 8'h00, 0);
      chk("own id read", {nib[15], nib[14], accessAddr},
         {8'h96, 19'h00010});
      strap <= 4'h0;
      repeat (4) @(posedge sys_clk);
      $display("test strap done");
   endtask

   // Reset in mid-read while the device drives the bus
   task automatic t_reset();
      reqValid <= 1'b1;
      reqWrite <= 1'b0;
      reqAddr <= 32'hfffa_bcde;
      @(posedge sys_clk);
      reqValid <= 1'b0;
      repeat (13) @(posedge sys_clk);
      chk("ready in cycle", reqReady, 1'b0);
      chk("sync before reset", {link.devLadOeN, link.lad}, 5'h00);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("drive in reset", link.devLadOeN, 1'b1);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      $display("test reset done");
   endtask

   // Raw read-shaped cycle with chosen frame nibbles and type
   task automatic raw(input logic [3:0] s0, s1, ty, input logic acc);
      logic [3:0] nb [12:16];
      int rs;
      rs = 0;
      for (int k = 0; k <= 12; k++)
      begin
         @(posedge sys_clk);
         rs += readStrobeB;
         linkB.frameN <= (k > 1);
         linkB.hostLadOeN <= (k == 12);
         linkB.hostLad <= k == 0 ? s0 : k == 1 ? s1 : k == 2 ? ty :
            k >= 11 ? NIB_TURN : 4'(RAW_ADDR >> (40 - 4 * k));
      end
      for (int k = 12; k <= 16; k++)
      begin
         @(posedge sys_clk);
         rs += readStrobeB;
         nb[k] = linkB.lad;
      end
      linkB.hostLadOeN <= 1'b0;
      chk("raw strobe", rs, acc);
      chk("raw take", nb[12], NIB_TURN);
      chk("raw sync", nb[13], acc ? NIB_SYNC_READY : NIB_IDLE);
      if (acc)
         chk("raw addr", accessAddrB, 19'h12345);
      $display("test raw %h %h %h done", s0, s1, ty);
   endtask

   // Main sequence
   initial
   begin
      {nFail, totalChecks} = '0;
      {reset_n, busy, reqValid, reqWrite, abortReq} = '0;
      {strap, readData, reqData, reqAddr} = '0;
      linkB.frameN = 1'b1;
      linkB.hostLad = NIB_IDLE;
      linkB.hostLadOeN = 1'b0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_read(8'ha5);
      t_write(1'b0);
      t_write(1'b1);
      t_abort();
      t_strap();
      t_reset();
      raw(4'hf, 4'h0, 4'h4, 1'b1);
      raw(4'h0, 4'hf, 4'h4, 1'b0);
      raw(4'hf, 4'h1, 4'h4, 1'b0);
      raw(4'hf, 4'h0, 4'h8, 1'b0);
      raw(4'hf, 4'h0, 4'h5, 1'b1);
      raw(4'hf, 4'h0, 4'h0, 1'b0);
      endSim();
   end

   // Watchdog: tests need a few hundred clocks
   initial
   begin
      #(20 * 4000);
      nFail++;
      endSim();
   end
endmodule // lpc_memory_cycle_target_tb
